// File: rtl/timer_irq_cfg.svh
// register offsets, field positions and reset values of the interrupt register bank
`ifndef TIMER_IRQ_CFG_SVH
`define TIMER_IRQ_CFG_SVH
`define IRQ_ENABLE_CLEAR_OFS      8'h24
`define IRQ_ENABLE_SET_OFS        8'h28
`define IRQ_FLAG_STATUS_CLEAR_OFS 8'h2c
`define IRQ_REG_RESET             32'h00000000
`define IRQ_IMPL_MASK             32'h000ff80f
`define IRQ_BIT_WRAP              0
`define IRQ_BIT_RETRIGGER         1
`define IRQ_BIT_COUNTER_EVENT     2
`define IRQ_BIT_ERROR             3
`define IRQ_BIT_DEBUG_FAULT_STATE 11
`define IRQ_BIT_SOFT_FAULT_A      12
`define IRQ_BIT_SOFT_FAULT_B      13
`define IRQ_BIT_HARD_FAULT_LO     14
`define IRQ_BIT_MATCH_CAPTURE_LO  16
`define AXI_RESP_OKAY             2'b00
`define AXI_RESP_SLVERR           2'b10
`endif

// File: rtl/timer_irq_enable_flag_regs.sv
// interrupt enable set/clear and flag registers of the control timer, AXI4-Lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "timer_irq_cfg.svh"

module timer_irq_enable_flag_regs #(
  parameter int CHANNELS = 4
) (
  input  wire logic                ref_clk_in,
  input  wire logic                rst_n_in,
  input  wire logic [7:0]          s_axi_awaddr_in,
  input  wire logic                s_axi_awvalid_in,
  output logic                     s_axi_awready_out,
  input  wire logic [31:0]         s_axi_wdata_in,
  input  wire logic [3:0]          s_axi_wstrb_in,
  input  wire logic                s_axi_wvalid_in,
  output logic                     s_axi_wready_out,
  output logic [1:0]               s_axi_bresp_out,
  output logic                     s_axi_bvalid_out,
  input  wire logic                s_axi_bready_in,
  input  wire logic [7:0]          s_axi_araddr_in,
  input  wire logic                s_axi_arvalid_in,
  output logic                     s_axi_arready_out,
  output logic [31:0]              s_axi_rdata_out,
  output logic [1:0]               s_axi_rresp_out,
  output logic                     s_axi_rvalid_out,
  input  wire logic                s_axi_rready_in,
  input  wire logic [CHANNELS-1:0] match_capture_chan_evt_in,
  input  wire logic [CHANNELS-1:0] capture_mode_in,
  input  wire logic [CHANNELS-1:0] compare_capture_value_rd_in,
  input  wire logic [1:0]          hard_fault_evt_in,
  input  wire logic                soft_fault_b_evt_in,
  input  wire logic                soft_fault_a_evt_in,
  input  wire logic                debug_fault_state_evt_in,
  input  wire logic                counter_event_evt_in,
  input  wire logic                retrigger_evt_in,
  input  wire logic                wrap_evt_in,
  output logic                     irq_out
);

  function automatic timer_irq_pkg::reg_sel_e decode(input logic [7:0] addr);
    case (addr)
      `IRQ_ENABLE_CLEAR_OFS:      decode = timer_irq_pkg::REG_ENABLE_CLEAR;
      `IRQ_ENABLE_SET_OFS:        decode = timer_irq_pkg::REG_ENABLE_SET;
      `IRQ_FLAG_STATUS_CLEAR_OFS: decode = timer_irq_pkg::REG_FLAG;
      default:                    decode = timer_irq_pkg::REG_NONE;
    endcase
  endfunction

  function automatic timer_irq_pkg::word_t lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // write channel capture: address and data are taken in either order
  logic                 aw_held_ff;
  logic [7:0]           aw_addr_ff;
  logic                 w_held_ff;
  timer_irq_pkg::word_t w_data_ff;
  logic [3:0]           w_strb_ff;
  logic                 bvalid_ff;
  logic [1:0]           bresp_ff;
  logic                 rvalid_ff;
  logic [1:0]           rresp_ff;
  timer_irq_pkg::word_t rdata_ff;
  timer_irq_pkg::word_t enable_ff;
  timer_irq_pkg::word_t flag_ff;
  logic                 irq_ff;

  logic                     wr_fire;
  timer_irq_pkg::reg_sel_e  wr_sel;
  timer_irq_pkg::word_t     wr_ones;
  timer_irq_pkg::reg_sel_e  rd_sel;
  timer_irq_pkg::word_t     nxt_enable;
  timer_irq_pkg::word_t     nxt_flag;
  timer_irq_pkg::word_t     evt_vec;
  timer_irq_pkg::word_t     auto_clr;
  logic                     nxt_irq;
  timer_irq_pkg::word_t     flag_drop;

  assign s_axi_awready_out = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready_out  = !w_held_ff && !bvalid_ff;
  assign s_axi_arready_out = !rvalid_ff;
  assign wr_fire           = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_sel            = decode(aw_addr_ff);
  // strobe lanes gate which ones act; unimplemented bits never stick
  assign wr_ones           = w_data_ff & lane_mask(w_strb_ff) & `IRQ_IMPL_MASK;
  assign rd_sel            = decode(s_axi_araddr_in);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      w_held_ff <= 1'b0;
      w_data_ff <= `IRQ_REG_RESET;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata_in;
      w_strb_ff <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_sel == timer_irq_pkg::REG_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
    end else if (s_axi_bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end

  // both enable registers return the one shared enable store
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `AXI_RESP_OKAY;
      rdata_ff  <= `IRQ_REG_RESET;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= `AXI_RESP_OKAY;
      case (rd_sel)
        timer_irq_pkg::REG_ENABLE_CLEAR: rdata_ff <= enable_ff;
        timer_irq_pkg::REG_ENABLE_SET:   rdata_ff <= enable_ff;
        timer_irq_pkg::REG_FLAG:         rdata_ff <= flag_ff;
        default: begin
          rdata_ff <= `IRQ_REG_RESET;
          rresp_ff <= `AXI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out  = bresp_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rresp_out  = rresp_ff;
  assign s_axi_rdata_out  = rdata_ff;

  // write-one-set / write-one-clear on one store; zero bits keep state
  always_comb begin
    nxt_enable = enable_ff;
    if (wr_fire && wr_sel == timer_irq_pkg::REG_ENABLE_SET) begin
      nxt_enable = enable_ff | wr_ones;
    end else if (wr_fire && wr_sel == timer_irq_pkg::REG_ENABLE_CLEAR) begin
      nxt_enable = enable_ff & ~wr_ones;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      enable_ff <= `IRQ_REG_RESET;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // events come from logic on this clock; no synchroniser needed
  always_comb begin
    evt_vec = `IRQ_REG_RESET;
    auto_clr = `IRQ_REG_RESET;
    evt_vec[`IRQ_BIT_MATCH_CAPTURE_LO +: CHANNELS] = match_capture_chan_evt_in;
    evt_vec[`IRQ_BIT_HARD_FAULT_LO +: 2] = hard_fault_evt_in;
    evt_vec[`IRQ_BIT_SOFT_FAULT_B]       = soft_fault_b_evt_in;
    evt_vec[`IRQ_BIT_SOFT_FAULT_A]       = soft_fault_a_evt_in;
    evt_vec[`IRQ_BIT_DEBUG_FAULT_STATE]  = debug_fault_state_evt_in;
    evt_vec[`IRQ_BIT_COUNTER_EVENT]      = counter_event_evt_in;
    evt_vec[`IRQ_BIT_RETRIGGER]          = retrigger_evt_in;
    evt_vec[`IRQ_BIT_WRAP]               = wrap_evt_in;
    // a capture onto a still-pending channel has nowhere to go
    evt_vec[`IRQ_BIT_ERROR] = |(match_capture_chan_evt_in & capture_mode_in
                                & flag_ff[`IRQ_BIT_MATCH_CAPTURE_LO +: CHANNELS]);
    auto_clr[`IRQ_BIT_MATCH_CAPTURE_LO +: CHANNELS] =
      capture_mode_in & compare_capture_value_rd_in;
    nxt_flag = flag_ff;
    if (wr_fire && wr_sel == timer_irq_pkg::REG_FLAG) begin
      nxt_flag = nxt_flag & ~wr_ones;
    end
    // set wins over any clear in the same cycle
    nxt_flag = ((nxt_flag & ~auto_clr) | evt_vec) & `IRQ_IMPL_MASK;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      flag_ff <= `IRQ_REG_RESET;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign nxt_irq = |(flag_ff & enable_ff);

  // what may lower a flag this cycle: a write-one-clear or a capture read
  assign flag_drop = auto_clr
                   | ((wr_fire && wr_sel == timer_irq_pkg::REG_FLAG) ? wr_ones : `IRQ_REG_RESET);

  // registered so the request is glitch free
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq_out = irq_ff;

  property p_set_enables;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_fire && wr_sel == timer_irq_pkg::REG_ENABLE_SET) |=> ((enable_ff & $past(wr_ones)) == $past(wr_ones));
  endproperty
  a_set_enables: assert property (p_set_enables) else $error("set write missed an enable");

  property p_clear_disables;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_fire && wr_sel == timer_irq_pkg::REG_ENABLE_CLEAR) |=> ((enable_ff & $past(wr_ones)) == 32'h00000000);
  endproperty
  a_clear_disables: assert property (p_clear_disables) else $error("clear write left an enable");

  property p_zero_keeps;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_fire && wr_sel != timer_irq_pkg::REG_NONE && wr_sel != timer_irq_pkg::REG_FLAG)
      |=> ((enable_ff & ~$past(wr_ones)) == ($past(enable_ff) & ~$past(wr_ones)));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero bit changed an enable");

  property p_enable_read;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_axi_arvalid_in && s_axi_arready_out && rd_sel == timer_irq_pkg::REG_ENABLE_SET)
      |=> (s_axi_rvalid_out && s_axi_rdata_out == $past(enable_ff));
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable read data wrong");

  property p_event_sets_flag;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    wrap_evt_in |=> flag_ff[`IRQ_BIT_WRAP];
  endproperty
  a_event_sets_flag: assert property (p_event_sets_flag) else $error("wrap flag not set");

  property p_error_flag;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (|(match_capture_chan_evt_in & capture_mode_in
       & flag_ff[`IRQ_BIT_MATCH_CAPTURE_LO +: CHANNELS])) |=> flag_ff[`IRQ_BIT_ERROR];
  endproperty
  a_error_flag: assert property (p_error_flag) else $error("error flag not set");

  property p_read_clears;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (capture_mode_in[0] && compare_capture_value_rd_in[0] && !match_capture_chan_evt_in[0])
      |=> !flag_ff[16];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("channel flag not cleared");

  property p_irq;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ##1 (irq_out == $past(|(flag_ff & enable_ff)));
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow flag and enable");

  property p_reset_zero;
    @(posedge ref_clk_in)
    !rst_n_in |=> (enable_ff == 32'h00000000 && flag_ff == 32'h00000000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("registers not zero after reset");

  // both read paths must show the live store they name
  property p_clear_read;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_axi_arvalid_in && s_axi_arready_out && rd_sel == timer_irq_pkg::REG_ENABLE_CLEAR)
      |=> (s_axi_rvalid_out && s_axi_rdata_out == $past(enable_ff));
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("clear read data wrong");

  property p_flag_read;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (s_axi_arvalid_in && s_axi_arready_out && rd_sel == timer_irq_pkg::REG_FLAG)
      |=> (s_axi_rvalid_out && s_axi_rdata_out == $past(flag_ff));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read data wrong");

  property p_enable_hold;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !(wr_fire && (wr_sel == timer_irq_pkg::REG_ENABLE_SET
                  || wr_sel == timer_irq_pkg::REG_ENABLE_CLEAR)) |=> $stable(enable_ff);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable moved unasked");

  property p_counter_bit;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_fire && wr_sel == timer_irq_pkg::REG_ENABLE_SET && wr_ones[`IRQ_BIT_COUNTER_EVENT]
      && !wr_ones[`IRQ_BIT_RETRIGGER])
      |=> (enable_ff[`IRQ_BIT_COUNTER_EVENT] && $stable(enable_ff[`IRQ_BIT_RETRIGGER]));
  endproperty
  a_counter_bit: assert property (p_counter_bit) else $error("counter enable misset");

  property p_flag_clears;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (wr_fire && wr_sel == timer_irq_pkg::REG_FLAG)
      |=> ((flag_ff & $past(wr_ones) & ~$past(evt_vec)) == 32'h00000000);
  endproperty
  a_flag_clears: assert property (p_flag_clears) else $error("write one left a flag");

  property p_flag_sticky;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    ##1 (($past(flag_ff) & ~$past(flag_drop) & ~flag_ff) == 32'h00000000);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag fell by itself");

  property p_events_set;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (evt_vec != 32'h00000000) |=> ((flag_ff & $past(evt_vec)) == $past(evt_vec));
  endproperty
  a_events_set: assert property (p_events_set) else $error("event did not raise its flag");

  property p_error_cause;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (!flag_ff[`IRQ_BIT_ERROR] ##1 flag_ff[`IRQ_BIT_ERROR])
      |-> $past(|(match_capture_chan_evt_in & capture_mode_in
                  & flag_ff[`IRQ_BIT_MATCH_CAPTURE_LO +: CHANNELS]));
  endproperty
  a_error_cause: assert property (p_error_cause) else $error("error flag without a clash");

  property p_read_clears_all;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (auto_clr != 32'h00000000)
      |=> ((flag_ff & $past(auto_clr) & ~$past(evt_vec)) == 32'h00000000);
  endproperty
  a_read_clears_all: assert property (p_read_clears_all) else $error("read left a flag");

  // scenarios the bench is expected to reach
  c_write_set: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_fire && wr_sel == timer_irq_pkg::REG_ENABLE_SET);
  c_flag_clear: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_fire && wr_sel == timer_irq_pkg::REG_FLAG);
  c_irq_rise: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $rose(irq_out));
  c_error: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(flag_ff[`IRQ_BIT_ERROR]));
  c_read_clear: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    |(capture_mode_in & compare_capture_value_rd_in));

endmodule

// File: rtl/timer_irq_pkg.sv
// types shared by the interrupt register bank
package timer_irq_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {
    REG_ENABLE_CLEAR,
    REG_ENABLE_SET,
    REG_FLAG,
    REG_NONE
  } reg_sel_e;
endpackage

// File: verif/timer_irq_enable_flag_regs_tb_top.sv
// self-checking bench for the interrupt enable and flag register bank
`timescale 1ns/1ps
`include "timer_irq_cfg.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module timer_irq_enable_flag_regs_tb_top;
  localparam logic [31:0] impl_mask = `IRQ_IMPL_MASK;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic [7:0]  awaddr     = 8'h00;
  logic        awvalid    = 1'b0;
  logic [31:0] wdata      = 32'h00000000;
  logic [3:0]  wstrb      = 4'hf;
  logic        wvalid     = 1'b0;
  logic        bready     = 1'b0;
  logic [7:0]  araddr     = 8'h00;
  logic        arvalid    = 1'b0;
  logic        rready     = 1'b0;
  logic [19:0] evt        = 20'h00000;
  logic [3:0]  cap_mode   = 4'h0;
  logic [3:0]  cc_rd      = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int          errors       = 0;
  int          total_checks = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  timer_irq_enable_flag_regs DUT (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .match_capture_chan_evt_in(evt[19:16]), .capture_mode_in(cap_mode),
    .compare_capture_value_rd_in(cc_rd), .hard_fault_evt_in(evt[15:14]),
    .soft_fault_b_evt_in(evt[13]), .soft_fault_a_evt_in(evt[12]),
    .debug_fault_state_evt_in(evt[11]), .counter_event_evt_in(evt[2]),
    .retrigger_evt_in(evt[1]), .wrap_evt_in(evt[0]), .irq_out(irq)
  );

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic timed_out;
    errors++;
    $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    final_report();
  endtask

  // handshakes are judged at the negedge before the edge that completes them
  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
    bit aw_hs, w_hs, b_hs;
    int n;
    @(posedge ref_clk_in);
    awaddr <= addr; wdata <= data; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge ref_clk_in);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      resp = bresp;
      @(posedge ref_clk_in);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) timed_out();
  endtask

  task automatic axi_read(input logic [7:0] addr);
    bit ar_hs, r_hs;
    int n;
    @(posedge ref_clk_in);
    araddr <= addr; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge ref_clk_in);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      rd = rdata;
      resp = rresp;
      @(posedge ref_clk_in);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) timed_out();
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    axi_write(addr, data);
    `CHK(resp, `AXI_RESP_OKAY)
  endtask

  task automatic check_reg(input logic [7:0] addr, input logic [31:0] exp);
    axi_read(addr);
    `CHK(resp, `AXI_RESP_OKAY)
    `CHK(rd, exp)
  endtask

  task automatic pulse(input logic [19:0] m);
    @(posedge ref_clk_in);
    evt <= m;
    @(posedge ref_clk_in);
    evt <= 20'h00000;
  endtask

  task automatic t_reset;
    check_reg(`IRQ_ENABLE_CLEAR_OFS, `IRQ_REG_RESET);
    check_reg(`IRQ_ENABLE_SET_OFS, `IRQ_REG_RESET);
    check_reg(`IRQ_FLAG_STATUS_CLEAR_OFS, `IRQ_REG_RESET);
  endtask

  // every implemented enable alone through set, zero writes, then clear
  task automatic t_enables;
    for (int i = 0; i < 32; i++) begin
      if (impl_mask[i]) begin
        wr(`IRQ_ENABLE_SET_OFS, 32'h1 << i);
        check_reg(`IRQ_ENABLE_CLEAR_OFS, 32'h1 << i);
        wr(`IRQ_ENABLE_SET_OFS, 32'h0);
        wr(`IRQ_ENABLE_CLEAR_OFS, ~(32'h1 << i));
        check_reg(`IRQ_ENABLE_SET_OFS, 32'h1 << i);
        wr(`IRQ_ENABLE_CLEAR_OFS, 32'h1 << i);
        check_reg(`IRQ_ENABLE_SET_OFS, 32'h0);
      end
    end
    wstrb <= 4'h4;
    wr(`IRQ_ENABLE_SET_OFS, 32'hffffffff);
    wstrb <= 4'hf;
    check_reg(`IRQ_ENABLE_SET_OFS, 32'h000f0000);
    wr(`IRQ_ENABLE_SET_OFS, 32'hffffffff);
    check_reg(`IRQ_ENABLE_CLEAR_OFS, impl_mask);
    wr(`IRQ_ENABLE_CLEAR_OFS, 32'hffffffff);
    check_reg(`IRQ_ENABLE_SET_OFS, 32'h0);
  endtask

  // error flag has no event of its own, it is covered by the capture scenario
  task automatic t_flags;
    for (int i = 0; i < 20; i++) begin
      if (impl_mask[i] && i != `IRQ_BIT_ERROR) begin
        pulse(20'(32'h1 << i));
        check_reg(`IRQ_FLAG_STATUS_CLEAR_OFS, 32'h1 << i);
        @(negedge ref_clk_in);
        `CHK(irq, 1'b0)
        wr(`IRQ_ENABLE_SET_OFS, 32'h1 << i);
        repeat (2) @(negedge ref_clk_in);
        `CHK(irq, 1'b1)
        wr(`IRQ_FLAG_STATUS_CLEAR_OFS, ~(32'h1 << i));
        check_reg(`IRQ_FLAG_STATUS_CLEAR_OFS, 32'h1 << i);
        wr(`IRQ_FLAG_STATUS_CLEAR_OFS, 32'h1 << i);
        check_reg(`IRQ_FLAG_STATUS_CLEAR_OFS, 32'h0);
        repeat (2) @(negedge ref_clk_in);
        `CHK(irq, 1'b0)
        wr(`IRQ_ENABLE_CLEAR_OFS, 32'h1 << i);
      end
    end
  endtask

  task automatic t_capture;
    @(posedge ref_clk_in);
    cap_mode <= 4'h1;
    pulse(20'h10000);
    pulse(20'h10000);
    pulse(20'h20000);
    check_reg(`IRQ_FLAG_STATUS_CLEAR_OFS, 32'h00030008);
    @(posedge ref_clk_in);
    cc_rd <= 4'h3;
    @(posedge ref_clk_in);
    cc_rd <= 4'h0;
    check_reg(`IRQ_FLAG_STATUS_CLEAR_OFS, 32'h00020008);
    wr(`IRQ_FLAG_STATUS_CLEAR_OFS, 32'h00020008);
    check_reg(`IRQ_FLAG_STATUS_CLEAR_OFS, 32'h0);
    cap_mode <= 4'h0;
  endtask

  task automatic t_unmapped;
    axi_write(8'h30, 32'hffffffff);
    `CHK(resp, `AXI_RESP_SLVERR)
    axi_read(8'h30);
    `CHK(resp, `AXI_RESP_SLVERR)
    `CHK(rd, 32'h0)
    check_reg(`IRQ_ENABLE_SET_OFS, 32'h0);
  endtask

  // a mid-run reset must drop stored enables, flags and the request
  task automatic t_mid_reset;
    wr(`IRQ_ENABLE_SET_OFS, 32'hffffffff);
    pulse(20'hff807);
    repeat (2) @(negedge ref_clk_in);
    `CHK(irq, 1'b1)
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    @(negedge ref_clk_in);
    `CHK(irq, 1'b0)
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_enables();
    t_flags();
    t_capture();
    t_unmapped();
    t_mid_reset();
    final_report();
  end
endmodule
